// ===== hw/sfi_status_unit.sv
// Overview of operation
// - Status upper byte reports FIFO byte count
// - Threshold words compared as two bytes each
// - Writing bit 15 one clears FIFO
// - Second-slot flag sets on event, W1C
// - First-slot flag sets on event, W1C
// - Reserved bit 7 resets zero, W1C
// - Low reserved bits cleared only by writing all five ones
// - FIFO-level irq above threshold when unmasked
// - Second-slot irq only when unmasked
// - First-slot irq only when unmasked
// - Pin two drive mode: push-pull or open-drain
// - Pin two polarity: high or low active
// - Pin one disabled floats, flags keep updating
// - Pin one enable allows driving interrupt
// - Pin one drive mode: push-pull or open-drain
// - Pin one polarity: high or low active
// - FIFO irq drops when count not above
`include "sfi_defines.svh"
module sfi_status_unit
  import sfi_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int THR_W = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register port
  input wire sfi_bus_s bus,
  output logic [15:0] rdata,
  // FIFO side
  input wire logic [CNT_W-1:0] fifo_byte_count,
  output logic fifo_clear,
  // Slot sample events
  input wire logic first_slot_event,
  input wire logic second_slot_event,
  // Interrupt
  output logic irq,
  output sfi_pin_s irq_pin_one,
  output sfi_pin_s irq_pin_two
);
  // Byte count and threshold fields are fixed by the register layout
  if (CNT_W != 8 || THR_W != 6) begin : g_bad_widths
    $error("unsupported widths");
  end
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [15:0] mask;
    logic [15:0] pincfg;
    logic [THR_W-1:0] thresh;
    logic rsvd7;
    logic [4:0] rsvd_low;
    logic fifo_clear;
    logic [15:0] rdata;
  } sfi_state_s;
  sfi_state_s st_q;
  sfi_state_s st_d;
  logic wr_status;
  logic first_slot_event_flag;
  logic second_slot_event_flag;
  logic fifo_level;
  logic first_slot_irq_disable;
  logic second_slot_irq_disable;
  logic fifo_irq_disable;
  sfi_pincfg_s cfg_one;
  sfi_pincfg_s cfg_two;
  assign wr_status = bus.wr && bus.addr == `SFI_ADDR_STATUS;
  // ****************************************************************
  // Event flags
  // ****************************************************************
  sfi_event_flag u_first_flag (
    .core_clk(core_clk),
    .nrst(nrst),
    .set_i(first_slot_event),
    .clr_i(wr_status && bus.wdata[`SFI_BIT_SLOT1]),
    .flag(first_slot_event_flag)
  );
  sfi_event_flag u_second_flag (
    .core_clk(core_clk),
    .nrst(nrst),
    .set_i(second_slot_event),
    .clr_i(wr_status && bus.wdata[`SFI_BIT_SLOT2]),
    .flag(second_slot_event_flag)
  );
  // ****************************************************************
  // Registers
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    st_d.fifo_clear = wr_status && bus.wdata[`SFI_BIT_FIFO_CLR];
    if (wr_status && bus.wdata[`SFI_BIT_RSVD7]) begin
      st_d.rsvd7 = 1'b0;
    end
    if (wr_status && bus.wdata[4:0] == `SFI_RSVD_LOW_ONES) begin
      st_d.rsvd_low = 5'h00;
    end
    if (bus.wr) begin
      case (bus.addr)
        `SFI_ADDR_MASK: st_d.mask = bus.wdata;
        `SFI_ADDR_PINCFG: st_d.pincfg = bus.wdata;
        `SFI_ADDR_THRESH: st_d.thresh = bus.wdata[13:8];
        default: st_d.thresh = st_d.thresh;
      endcase
    end
    case (bus.addr)
      `SFI_ADDR_STATUS: st_d.rdata = {fifo_byte_count, st_q.rsvd7, second_slot_event_flag,
        first_slot_event_flag, st_q.rsvd_low};
      `SFI_ADDR_MASK: st_d.rdata = st_q.mask;
      `SFI_ADDR_PINCFG: st_d.rdata = st_q.pincfg;
      `SFI_ADDR_THRESH: st_d.rdata = {2'h0, st_q.thresh, 8'h00};
      default: st_d.rdata = 16'h0000;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_q.mask <= `SFI_MASK_RST;
      st_q.pincfg <= `SFI_PINCFG_RST;
      st_q.thresh <= `SFI_THRESH_RST;
      st_q.rsvd7 <= 1'b0;
      st_q.rsvd_low <= 5'h00;
      st_q.fifo_clear <= 1'b0;
      st_q.rdata <= 16'h0000;
    end else begin
      st_q <= st_d;
    end
  end
  assign rdata = st_q.rdata;
  assign fifo_clear = st_q.fifo_clear;
  // ****************************************************************
  // Interrupt
  // ****************************************************************
  assign first_slot_irq_disable = st_q.mask[`SFI_BIT_SLOT1];
  assign second_slot_irq_disable = st_q.mask[`SFI_BIT_SLOT2];
  assign fifo_irq_disable = st_q.mask[`SFI_BIT_FIFO_MASK];
  // Byte count halved to whole words before comparing
  assign fifo_level = fifo_byte_count[CNT_W-1:1] > {1'b0, st_q.thresh};
  assign irq = (first_slot_event_flag && !first_slot_irq_disable)
    || (second_slot_event_flag && !second_slot_irq_disable)
    || (fifo_level && !fifo_irq_disable);
  assign cfg_one = '{ena: st_q.pincfg[`SFI_BIT_P1_ENA], drv: st_q.pincfg[`SFI_BIT_P1_DRV],
    pol: st_q.pincfg[`SFI_BIT_P1_POL]};
  assign cfg_two = '{ena: 1'b1, drv: st_q.pincfg[`SFI_BIT_P2_DRV], pol: st_q.pincfg[`SFI_BIT_P2_POL]};
  sfi_irq_pin u_pin_one (
    .cfg(cfg_one),
    .irq(irq),
    .pin(irq_pin_one)
  );
  sfi_irq_pin u_pin_two (
    .cfg(cfg_two),
    .irq(irq),
    .pin(irq_pin_two)
  );
  // ****************************************************************
  // Checks
  // ****************************************************************
  a_fifo_clear_pulse: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_status && bus.wdata[15] |=> fifo_clear ##1 !fifo_clear || (wr_status && bus.wdata[15]))
    else $error("fifo clear not pulsed");
  a_first_masked: assert property (@(posedge core_clk) disable iff (!nrst)
    first_slot_event_flag && !first_slot_irq_disable |-> irq)
    else $error("first slot irq missing");
  a_second_masked: assert property (@(posedge core_clk) disable iff (!nrst)
    second_slot_event_flag && !second_slot_irq_disable |-> irq)
    else $error("second slot irq missing");
  a_fifo_level_irq: assert property (@(posedge core_clk) disable iff (!nrst)
    fifo_byte_count > {st_q.thresh, 1'b1} && !fifo_irq_disable |-> irq)
    else $error("fifo irq missing");
  a_irq_idle_low: assert property (@(posedge core_clk) disable iff (!nrst)
    !first_slot_event_flag && !second_slot_event_flag && fifo_byte_count < 8'h02 |-> !irq)
    else $error("spurious irq");
  a_pin_two_pol: assert property (@(posedge core_clk) disable iff (!nrst)
    irq_pin_two.out == (irq ^ st_q.pincfg[8]))
    else $error("pin two level wrong");
  a_pin_two_drv: assert property (@(posedge core_clk) disable iff (!nrst)
    !st_q.pincfg[9] |-> irq_pin_two.oe)
    else $error("pin two not driven");
  a_pin_one_float: assert property (@(posedge core_clk) disable iff (!nrst)
    !st_q.pincfg[2] |-> !irq_pin_one.oe)
    else $error("pin one driven while disabled");
  a_pin_one_drv: assert property (@(posedge core_clk) disable iff (!nrst)
    st_q.pincfg[2] && st_q.pincfg[1] |-> irq_pin_one.oe == irq)
    else $error("pin one open drain wrong");
  a_status_read: assert property (@(posedge core_clk) disable iff (!nrst)
    bus.addr == 8'h00 |=> rdata[15:8] == $past(fifo_byte_count))
    else $error("byte count read wrong");
endmodule // sfi_status_unit

// ===== include/sfi_defines.svh
`ifndef SFI_DEFINES_SVH
`define SFI_DEFINES_SVH
// ****************************************************************
// Register indices
// ****************************************************************
`define SFI_ADDR_STATUS 8'h00
`define SFI_ADDR_MASK 8'h01
`define SFI_ADDR_PINCFG 8'h02
`define SFI_ADDR_THRESH 8'h06
// ****************************************************************
// Field positions
// ****************************************************************
`define SFI_BIT_FIFO_CLR 15
`define SFI_BIT_RSVD7 7
`define SFI_BIT_SLOT2 6
`define SFI_BIT_SLOT1 5
`define SFI_BIT_FIFO_MASK 8
`define SFI_BIT_P2_DRV 9
`define SFI_BIT_P2_POL 8
`define SFI_BIT_P1_ENA 2
`define SFI_BIT_P1_DRV 1
`define SFI_BIT_P1_POL 0
`define SFI_RSVD_LOW_ONES 5'h1f
// ****************************************************************
// Reset values
// ****************************************************************
`define SFI_MASK_RST 16'h01ff
`define SFI_PINCFG_RST 16'h0000
`define SFI_THRESH_RST 6'h00
`endif

// ===== include/sfi_pkg.sv
package sfi_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } sfi_bus_s;
  typedef struct packed {
    logic out;
    logic oe;
  } sfi_pin_s;
  typedef struct packed {
    logic ena;
    logic drv;
    logic pol;
  } sfi_pincfg_s;
endpackage

// ===== hw/sfi_event_flag.sv
module sfi_event_flag
  import sfi_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Event and clear
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag
);
  typedef struct packed {
    logic flag;
  } sfi_flag_s;
  sfi_flag_s st_q;
  sfi_flag_s st_d;
  always_comb begin
    st_d = st_q;
    // Set wins over a clear in the same cycle
    if (set_i) begin
      st_d.flag = 1'b1;
    end else if (clr_i) begin
      st_d.flag = 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign flag = st_q.flag;
  a_flag_set_wins: assert property (@(posedge core_clk) disable iff (!nrst) set_i |=> flag)
    else $error("event flag not set");
  a_flag_clear_ok: assert property (@(posedge core_clk) disable iff (!nrst) clr_i && !set_i |=> !flag)
    else $error("event flag not cleared");
endmodule // sfi_event_flag

// ===== hw/sfi_irq_pin.sv
module sfi_irq_pin
  import sfi_pkg::*;
(
  // Configuration
  input wire sfi_pincfg_s cfg,
  // Interrupt level
  input wire logic irq,
  // Pin
  output sfi_pin_s pin
);
  always_comb begin
    pin.out = irq ^ cfg.pol;
    pin.oe = cfg.ena && (!cfg.drv || irq);
  end
  // Checked from the owning module, which has the clock; this block is purely combinational
  always_comb begin
    a_pin_float_off: assert #0 (cfg.ena || !pin.oe)
      else $error("pin driven while disabled");
  end
endmodule // sfi_irq_pin

// ===== testbench/sfi_host_model.sv
module sfi_host_model
  import sfi_pkg::*;
(
  // Device pins
  input wire sfi_pin_s pin_one,
  input wire sfi_pin_s pin_two,
  // Board wires
  output logic wire_one,
  output logic wire_two
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-downs take released lines low
  assign wire_one = pin_one.oe ? pin_one.out : 1'b0;
  assign wire_two = pin_two.oe ? pin_two.out : 1'b0;
endmodule // sfi_host_model

// ===== testbench/sfi_status_unit_test.sv
`include "sfi_defines.svh"
module sfi_status_unit_test
  import sfi_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] cfg;
    logic [7:0] cnt;
    logic irq;
    logic [1:0] p1;
    logic [1:0] p2;
  } sfi_row_s;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  sfi_bus_s bus = '0;
  logic [7:0] fifo_byte_count = 8'h00;
  logic first_slot_event = 1'b0;
  logic second_slot_event = 1'b0;
  logic [15:0] rdata;
  logic fifo_clear, irq, wire_one, wire_two;
  sfi_pin_s irq_pin_one, irq_pin_two;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int clr_cnt = 0;
  sfi_row_s rows [7] = '{'{16'h0000, 8'h08, 1'b1, 2'b00, 2'b11}, '{16'h0004, 8'h08, 1'b1, 2'b11, 2'b11},
    '{16'h0005, 8'h06, 1'b0, 2'b11, 2'b01}, '{16'h0006, 8'h07, 1'b0, 2'b00, 2'b01},
    '{16'h0307, 8'h08, 1'b1, 2'b01, 2'b01}, '{16'h0307, 8'h06, 1'b0, 2'b00, 2'b00},
    '{16'h0100, 8'h00, 1'b0, 2'b00, 2'b11}};
  sfi_status_unit i_sfi_status_unit (.core_clk(core_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
    .fifo_byte_count(fifo_byte_count), .fifo_clear(fifo_clear), .first_slot_event(first_slot_event),
    .second_slot_event(second_slot_event), .irq(irq), .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two));
  sfi_host_model i_sfi_host_model (.pin_one(irq_pin_one), .pin_two(irq_pin_two), .wire_one(wire_one),
    .wire_two(wire_two));
  // ****
  // Helpers
  // ****
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    clr_cnt <= clr_cnt + int'(fifo_clear === 1'b1);
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Output level only matters while the pin is driven
  task automatic cmp_pin(input sfi_pin_s got, input logic [1:0] exp);
    cmp_word(16'(exp[0] ? got : {1'b0, got.oe}), 16'(exp[0] ? exp : 2'b00));
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge core_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge core_clk);
    bus.rd <= 1'b0;
    cmp_word(rdata, exp);
  endtask
  task automatic pulse(input logic second);
    @(negedge core_clk);
    first_slot_event <= ~second;
    second_slot_event <= second;
    @(negedge core_clk);
    first_slot_event <= 1'b0;
    second_slot_event <= 1'b0;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    repeat (4) @(negedge core_clk);
    nrst <= 1'b1;
    rd(`SFI_ADDR_MASK, 16'h01ff);
    rd(`SFI_ADDR_PINCFG, 16'h0000);
    rd(`SFI_ADDR_STATUS, 16'h0000);
    cmp_pin(irq_pin_one, 2'b00);
    cmp_pin(irq_pin_two, 2'b01);
    wr(`SFI_ADDR_MASK, 16'h0000);
    wr(`SFI_ADDR_THRESH, 16'h0300);
    foreach (rows[i]) begin
      wr(`SFI_ADDR_PINCFG, rows[i].cfg);
      fifo_byte_count <= rows[i].cnt;
      @(negedge core_clk);
      cmp_word(16'(irq), 16'(rows[i].irq));
      cmp_pin(irq_pin_one, rows[i].p1);
      cmp_pin(irq_pin_two, rows[i].p2);
      cmp_word(16'(wire_one), 16'(rows[i].p1[0] & rows[i].p1[1]));
      cmp_word(16'(wire_two), 16'(rows[i].p2[0] & rows[i].p2[1]));
    end
    fifo_byte_count <= 8'h5a;
    rd(`SFI_ADDR_STATUS, 16'h5a00);
    cmp_word(16'(irq), 16'h0001);
    wr(`SFI_ADDR_MASK, 16'h01ff);
    cmp_word(16'(irq), 16'h0000);
    fifo_byte_count <= 8'h00;
    pulse(1'b0);
    pulse(1'b1);
    cmp_word(16'(irq), 16'h0000);
    wr(`SFI_ADDR_STATUS, 16'h0000);
    rd(`SFI_ADDR_STATUS, 16'h0060);
    wr(`SFI_ADDR_MASK, 16'h01bf);
    cmp_word(16'(irq), 16'h0001);
    cmp_pin(irq_pin_one, 2'b00);
    wr(`SFI_ADDR_STATUS, 16'h0040);
    cmp_word(16'(irq), 16'h0000);
    wr(`SFI_ADDR_MASK, 16'h019f);
    cmp_word(16'(irq), 16'h0001);
    wr(`SFI_ADDR_STATUS, 16'h00bf);
    rd(`SFI_ADDR_STATUS, 16'h0000);
    wr(`SFI_ADDR_STATUS, 16'h8000);
    repeat (3) @(negedge core_clk);
    cmp_word(16'(clr_cnt), 16'h0001);
    nrst <= 1'b0;
    repeat (4) @(negedge core_clk);
    nrst <= 1'b1;
    rd(`SFI_ADDR_MASK, 16'h01ff);
    end_sim();
  end
endmodule // sfi_status_unit_test
